// ===== core/ppfm_pkg.sv
package ppfm_pkg;
	// Port widths
	localparam int P0_W = 8;
	localparam int P1_W = 5;
	localparam int P23_W = 16;
	localparam int P4_W = 5;
	localparam int P5_W = 5;
	localparam int P6_W = 2;
	localparam int P8_W = 7;
	localparam int P9_W = 8;
	localparam int IRQ_W = 3;
	localparam int CAP_W = 3;
	localparam int TIO_W = 2;
	localparam int MTR_GRPS = 4;
	localparam int MTR_GRP_W = 4;
	localparam int SEG_W = 20;
	localparam int SEG_FIX_W = 5;
	localparam int COM_W = 4;
	localparam int SEG_PAIRS = 8;
	// Pin positions of the alternate functions
	localparam int P0_SCK = 3;
	localparam int P0_SO = 4;
	localparam int P0_SI = 5;
	localparam int P4_TIO_LSB = 3;
	localparam int P5_SCK = 0;
	localparam int P5_SO = 1;
	localparam int P5_SI = 2;
	localparam int P5_RXD = 3;
	localparam int P5_TXD = 4;
	localparam int P6_CLK = 0;
	localparam int P6_SND = 1;
	// Segment numbering of the shared LCD pins
	localparam int P8_FIRST_PIN = 1;
	localparam int P8_SEG_TOP = 20;
	localparam int P9_SEG_TOP = 12;
	localparam int SEG_SHARED_LO = 5;
	// Reset values
	localparam logic RST_BIT = 1'b0;
	localparam logic DRIVE_BIT = 1'b1;
	typedef enum logic [1:0] {
		EDGE_RISE,
		EDGE_FALL,
		EDGE_BOTH
	} ppfm_edge_type;
endpackage : ppfm_pkg

// ===== core/ppfm_port_mux.sv
`timescale 1ns/10ps
module ppfm_port_mux
	import ppfm_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	// Port 0
	input wire logic [P0_W-1:0] p0_pin_in,
	input wire logic [P0_W-1:0] p0_latch_in,
	input wire logic [P0_W-1:0] p0_dir_in,
	input wire logic [P0_W-1:0] p0_pullup_en_in,
	output logic [P0_W-1:0] p0_pin_out,
	output logic [P0_W-1:0] p0_pin_oe_out,
	output logic [P0_W-1:0] p0_pullup_out,
	output logic [P0_W-1:0] p0_read_out,
	input wire ppfm_edge_type irq_edge_in [IRQ_W],
	output logic [IRQ_W-1:0] ext_irq_inputs_out,
	input wire logic sio_a_en_in,
	input wire logic sio_a_sck_oe_in,
	input wire logic sio_a_sck_in,
	input wire logic sio_a_so_in,
	output logic sio_a_sck_out,
	output logic sio_a_si_out,
	// Port 1
	input wire logic [P1_W-1:0] p1_pin_in,
	input wire logic [P1_W-1:0] analog_sel_in,
	output logic [P1_W-1:0] p1_read_out,
	// Ports 2 and 3
	input wire logic [P23_W-1:0] p23_latch_in,
	input wire logic [P23_W-1:0] p23_dir_in,
	input wire logic [MTR_GRPS-1:0] meter_grp_en_in,
	input wire logic [P23_W-1:0] meter_drive_outputs_in,
	output logic [P23_W-1:0] p23_pin_out,
	output logic [P23_W-1:0] p23_pin_oe_out,
	// Port 4
	input wire logic [P4_W-1:0] p4_pin_in,
	input wire logic [P4_W-1:0] p4_latch_in,
	input wire logic [P4_W-1:0] p4_dir_in,
	input wire logic [TIO_W-1:0] timer8_io_oe_in,
	input wire logic [TIO_W-1:0] timer8_io_drive_in,
	output logic [P4_W-1:0] p4_pin_out,
	output logic [P4_W-1:0] p4_pin_oe_out,
	output logic [P4_W-1:0] p4_read_out,
	output logic [CAP_W-1:0] capture_trigger_inputs_out,
	output logic [TIO_W-1:0] timer8_io_pins_out,
	// Port 5
	input wire logic [P5_W-1:0] p5_pin_in,
	input wire logic [P5_W-1:0] p5_latch_in,
	input wire logic [P5_W-1:0] p5_dir_in,
	input wire logic sio_b_en_in,
	input wire logic sio_b_sck_oe_in,
	input wire logic sio_b_sck_in,
	input wire logic sio_b_so_in,
	input wire logic uart_en_in,
	input wire logic uart_txd_in,
	output logic [P5_W-1:0] p5_pin_out,
	output logic [P5_W-1:0] p5_pin_oe_out,
	output logic [P5_W-1:0] p5_read_out,
	output logic sio_b_sck_out,
	output logic sio_b_si_out,
	output logic uart_rxd_out,
	// Port 6
	input wire logic [P6_W-1:0] p6_pin_in,
	input wire logic [P6_W-1:0] p6_latch_in,
	input wire logic [P6_W-1:0] p6_dir_in,
	input wire logic clk_out_en_in,
	input wire logic clk_out_sel_tpo_in,
	input wire logic programmable_clock_in,
	input wire logic timer_prescaler_in,
	input wire logic sound_gen_en_in,
	input wire logic sound_gen_in,
	output logic [P6_W-1:0] p6_pin_out,
	output logic [P6_W-1:0] p6_pin_oe_out,
	output logic [P6_W-1:0] p6_read_out,
	// Ports 8 and 9, LCD
	input wire logic [P8_W-1:0] p8_pin_in,
	input wire logic [P8_W-1:0] p8_latch_in,
	input wire logic [P8_W-1:0] p8_dir_in,
	input wire logic [P9_W-1:0] p9_pin_in,
	input wire logic [P9_W-1:0] p9_latch_in,
	input wire logic [P9_W-1:0] p9_dir_in,
	input wire logic [SEG_PAIRS-1:0] lcd_display_control_reg_in,
	input wire logic [SEG_W-1:0] segment_drive_in,
	input wire logic [COM_W-1:0] common_drive_in,
	output logic [P8_W-1:0] p8_pin_out,
	output logic [P8_W-1:0] p8_pin_oe_out,
	output logic [P8_W-1:0] p8_read_out,
	output logic [P9_W-1:0] p9_pin_out,
	output logic [P9_W-1:0] p9_pin_oe_out,
	output logic [P9_W-1:0] p9_read_out,
	output logic [SEG_FIX_W-1:0] segment_outputs_out,
	output logic [COM_W-1:0] common_outputs_out
);
	// Two-stage synchronisers; stage one feeds only stage two
	logic [P0_W-1:0] p0_s1_r, p0_s2_r, p0_prev_r;
	logic [P1_W-1:0] p1_s1_r, p1_s2_r;
	logic [P4_W-1:0] p4_s1_r, p4_s2_r;
	logic [P5_W-1:0] p5_s1_r, p5_s2_r;
	logic [P6_W-1:0] p6_s1_r, p6_s2_r;
	logic [P8_W-1:0] p8_s1_r, p8_s2_r;
	logic [P9_W-1:0] p9_s1_r, p9_s2_r;

	// Alternate-function ownership, per pin
	wire [P0_W-1:0] p0_alt, p0_aoe, p0_aout;
	wire [P4_W-1:0] p4_alt, p4_aoe, p4_aout;
	wire [P5_W-1:0] p5_alt, p5_aoe, p5_aout;
	wire [P6_W-1:0] p6_alt, p6_aoe, p6_aout;
	wire [P8_W-1:0] p8_seg, p8_sdat;
	wire [P9_W-1:0] p9_seg, p9_sdat;
	wire [P23_W-1:0] p23_mtr;

	// Serial A clock, out, in on port 0; pins 0-2 stay ports and feed interrupts
	assign p0_alt = {{(P0_W-P0_SI-1){1'b0}}, {3{sio_a_en_in}}, {P0_SCK{1'b0}}};
	assign p0_aoe = {{(P0_W-P0_SI-1){1'b0}}, 1'b0, 1'b1, sio_a_sck_oe_in, {P0_SCK{1'b0}}};
	assign p0_aout = {{(P0_W-P0_SI-1){1'b0}}, 1'b0, sio_a_so_in, sio_a_sck_in, {P0_SCK{1'b0}}};

	// Capture inputs stay port-sampled; timer I/O owns pins 3,4 when driving
	assign p4_alt = {timer8_io_oe_in, {P4_TIO_LSB{1'b0}}};
	assign p4_aoe = {timer8_io_oe_in, {P4_TIO_LSB{1'b0}}};
	assign p4_aout = {timer8_io_drive_in, {P4_TIO_LSB{1'b0}}};

	// Order: clock, data out, data in, receive, transmit
	assign p5_alt = {uart_en_in, uart_en_in, {3{sio_b_en_in}}};
	assign p5_aoe = {1'b1, 1'b0, 1'b0, 1'b1, sio_b_sck_oe_in};
	assign p5_aout = {uart_txd_in, 1'b0, 1'b0, sio_b_so_in, sio_b_sck_in};

	// Pin 0 clock or prescaler, pin 1 sound
	assign p6_alt = {sound_gen_en_in, clk_out_en_in};
	assign p6_aoe = {1'b1, 1'b1};
	assign p6_aout = {sound_gen_in,
		clk_out_sel_tpo_in ? timer_prescaler_in : programmable_clock_in};

	// Meter groups of four take over the output-only pins
	genvar g, i;
	generate
		for (g = 0; g < MTR_GRPS; g++) begin : g_mtr
			assign p23_mtr[g*MTR_GRP_W +: MTR_GRP_W] = {MTR_GRP_W{meter_grp_en_in[g]}};
		end
		// Segment k = seg-5 pairs with its neighbour; seg 19 stands alone in pair 7
		for (i = 0; i < P9_W; i++) begin : g_p9
			localparam int SEG = P9_SEG_TOP - i;
			assign p9_seg[i] = lcd_display_control_reg_in[(SEG - SEG_SHARED_LO) / 2];
			assign p9_sdat[i] = segment_drive_in[SEG];
		end
		for (i = 0; i < P8_W; i++) begin : g_p8
			localparam int SEG = P8_SEG_TOP - (i + P8_FIRST_PIN);
			assign p8_seg[i] = lcd_display_control_reg_in[(SEG - SEG_SHARED_LO) / 2];
			assign p8_sdat[i] = segment_drive_in[SEG];
		end
	endgenerate

	// Drive selection: peripheral wins over the port latch
	wire [P0_W-1:0] p0_oe_nxt = (p0_alt & p0_aoe) | (~p0_alt & p0_dir_in);
	wire [P0_W-1:0] p0_out_nxt = (p0_alt & p0_aout) | (~p0_alt & p0_latch_in);
	wire [P4_W-1:0] p4_oe_nxt = (p4_alt & p4_aoe) | (~p4_alt & p4_dir_in);
	wire [P4_W-1:0] p4_out_nxt = (p4_alt & p4_aout) | (~p4_alt & p4_latch_in);
	wire [P5_W-1:0] p5_oe_nxt = (p5_alt & p5_aoe) | (~p5_alt & p5_dir_in);
	wire [P5_W-1:0] p5_out_nxt = (p5_alt & p5_aout) | (~p5_alt & p5_latch_in);
	wire [P6_W-1:0] p6_oe_nxt = (p6_alt & p6_aoe) | (~p6_alt & p6_dir_in);
	wire [P6_W-1:0] p6_out_nxt = (p6_alt & p6_aout) | (~p6_alt & p6_latch_in);
	wire [P8_W-1:0] p8_oe_nxt = p8_seg | p8_dir_in;
	wire [P8_W-1:0] p8_out_nxt = (p8_seg & p8_sdat) | (~p8_seg & p8_latch_in);
	wire [P9_W-1:0] p9_oe_nxt = p9_seg | p9_dir_in;
	wire [P9_W-1:0] p9_out_nxt = (p9_seg & p9_sdat) | (~p9_seg & p9_latch_in);
	wire [P23_W-1:0] p23_oe_nxt = p23_mtr | p23_dir_in;
	wire [P23_W-1:0] p23_out_nxt = (p23_mtr & meter_drive_outputs_in) | (~p23_mtr & p23_latch_in);

	// Pull-up only while nobody drives the pin
	wire [P0_W-1:0] p0_pu_nxt = p0_pullup_en_in & ~p0_oe_nxt;

	// Port reads: latch for bits whose direction is output, pin otherwise
	wire [P0_W-1:0] p0_rd_nxt = (p0_dir_in & p0_latch_in) | (~p0_dir_in & p0_s2_r);
	wire [P4_W-1:0] p4_rd_nxt = (p4_dir_in & p4_latch_in) | (~p4_dir_in & p4_s2_r);
	wire [P5_W-1:0] p5_rd_nxt = (p5_dir_in & p5_latch_in) | (~p5_dir_in & p5_s2_r);
	wire [P6_W-1:0] p6_rd_nxt = (p6_dir_in & p6_latch_in) | (~p6_dir_in & p6_s2_r);
	wire [P8_W-1:0] p8_rd_nxt = (p8_dir_in & p8_latch_in) | (~p8_dir_in & p8_s2_r);
	wire [P9_W-1:0] p9_rd_nxt = (p9_dir_in & p9_latch_in) | (~p9_dir_in & p9_s2_r);
	// Analog-selected bits read zero so the digital buffer sees no mid-level
	wire [P1_W-1:0] p1_rd_nxt = p1_s2_r & ~analog_sel_in;

	// Edge detection on the second stage, never on the first
	logic [IRQ_W-1:0] irq_nxt;
	always_comb begin
		for (int n = 0; n < IRQ_W; n++) begin
			unique case (irq_edge_in[n])
				EDGE_RISE: irq_nxt[n] = p0_s2_r[n] & ~p0_prev_r[n];
				EDGE_FALL: irq_nxt[n] = ~p0_s2_r[n] & p0_prev_r[n];
				EDGE_BOTH: irq_nxt[n] = p0_s2_r[n] ^ p0_prev_r[n];
				default: irq_nxt[n] = RST_BIT;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		p0_s1_r <= p0_pin_in;
		p0_s2_r <= p0_s1_r;
		p0_prev_r <= p0_s2_r;
		p1_s1_r <= p1_pin_in;
		p1_s2_r <= p1_s1_r;
		p4_s1_r <= p4_pin_in;
		p4_s2_r <= p4_s1_r;
		p5_s1_r <= p5_pin_in;
		p5_s2_r <= p5_s1_r;
		p6_s1_r <= p6_pin_in;
		p6_s2_r <= p6_s1_r;
		p8_s1_r <= p8_pin_in;
		p8_s2_r <= p8_s1_r;
		p9_s1_r <= p9_pin_in;
		p9_s2_r <= p9_s1_r;
	end

	// Every output registered; all port pins released to input or Hi-Z by reset, fixed segment and common outputs driven low
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			p0_pin_oe_out <= {P0_W{RST_BIT}};
			p4_pin_oe_out <= {P4_W{RST_BIT}};
			p5_pin_oe_out <= {P5_W{RST_BIT}};
			p6_pin_oe_out <= {P6_W{RST_BIT}};
			p8_pin_oe_out <= {P8_W{RST_BIT}};
			p9_pin_oe_out <= {P9_W{RST_BIT}};
			p23_pin_oe_out <= {P23_W{RST_BIT}};
			p0_pin_out <= {P0_W{RST_BIT}};
			p4_pin_out <= {P4_W{RST_BIT}};
			p5_pin_out <= {P5_W{RST_BIT}};
			p6_pin_out <= {P6_W{RST_BIT}};
			p8_pin_out <= {P8_W{RST_BIT}};
			p9_pin_out <= {P9_W{RST_BIT}};
			p23_pin_out <= {P23_W{RST_BIT}};
			p0_pullup_out <= {P0_W{RST_BIT}};
			p0_read_out <= {P0_W{RST_BIT}};
			p1_read_out <= {P1_W{RST_BIT}};
			p4_read_out <= {P4_W{RST_BIT}};
			p5_read_out <= {P5_W{RST_BIT}};
			p6_read_out <= {P6_W{RST_BIT}};
			p8_read_out <= {P8_W{RST_BIT}};
			p9_read_out <= {P9_W{RST_BIT}};
			ext_irq_inputs_out <= {IRQ_W{RST_BIT}};
			capture_trigger_inputs_out <= {CAP_W{RST_BIT}};
			timer8_io_pins_out <= {TIO_W{RST_BIT}};
			sio_a_sck_out <= RST_BIT;
			sio_a_si_out <= RST_BIT;
			sio_b_sck_out <= RST_BIT;
			sio_b_si_out <= RST_BIT;
			uart_rxd_out <= RST_BIT;
			segment_outputs_out <= {SEG_FIX_W{RST_BIT}};
			common_outputs_out <= {COM_W{RST_BIT}};
		end else begin
			p0_pin_oe_out <= p0_oe_nxt;
			p4_pin_oe_out <= p4_oe_nxt;
			p5_pin_oe_out <= p5_oe_nxt;
			p6_pin_oe_out <= p6_oe_nxt;
			p8_pin_oe_out <= p8_oe_nxt;
			p9_pin_oe_out <= p9_oe_nxt;
			p23_pin_oe_out <= p23_oe_nxt;
			p0_pin_out <= p0_out_nxt;
			p4_pin_out <= p4_out_nxt;
			p5_pin_out <= p5_out_nxt;
			p6_pin_out <= p6_out_nxt;
			p8_pin_out <= p8_out_nxt;
			p9_pin_out <= p9_out_nxt;
			p23_pin_out <= p23_out_nxt;
			p0_pullup_out <= p0_pu_nxt;
			p0_read_out <= p0_rd_nxt;
			p1_read_out <= p1_rd_nxt;
			p4_read_out <= p4_rd_nxt;
			p5_read_out <= p5_rd_nxt;
			p6_read_out <= p6_rd_nxt;
			p8_read_out <= p8_rd_nxt;
			p9_read_out <= p9_rd_nxt;
			ext_irq_inputs_out <= irq_nxt;
			capture_trigger_inputs_out <= p4_s2_r[CAP_W-1:0];
			timer8_io_pins_out <= p4_s2_r[P4_TIO_LSB +: TIO_W];
			// Peripheral samples the pin itself, whatever the port direction
			sio_a_sck_out <= p0_s2_r[P0_SCK];
			sio_a_si_out <= p0_s2_r[P0_SI];
			sio_b_sck_out <= p5_s2_r[P5_SCK];
			sio_b_si_out <= p5_s2_r[P5_SI];
			uart_rxd_out <= p5_s2_r[P5_RXD];
			segment_outputs_out <= segment_drive_in[SEG_FIX_W-1:0];
			common_outputs_out <= common_drive_in;
		end
	end
endmodule : ppfm_port_mux

// ===== tb/ppfm_port_mux_monitor.sv
`timescale 1ns/10ps
module ppfm_port_mux_monitor
	import ppfm_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [P0_W-1:0] p0_pin_in,
	input wire logic [P0_W-1:0] p0_dir_in,
	input wire logic [P0_W-1:0] p0_pullup_en_in,
	input wire logic sio_a_en_in,
	input wire logic [P0_W-1:0] p0_pin_oe_out,
	input wire logic [P0_W-1:0] p0_pullup_out,
	input wire ppfm_edge_type irq_edge_in [IRQ_W],
	input wire logic [IRQ_W-1:0] ext_irq_inputs_out,
	input wire logic [P1_W-1:0] analog_sel_in,
	input wire logic [P1_W-1:0] p1_read_out,
	input wire logic [P23_W-1:0] p23_latch_in,
	input wire logic [P23_W-1:0] p23_dir_in,
	input wire logic [MTR_GRPS-1:0] meter_grp_en_in,
	input wire logic [P23_W-1:0] meter_drive_outputs_in,
	input wire logic [P23_W-1:0] p23_pin_out,
	input wire logic [P23_W-1:0] p23_pin_oe_out,
	input wire logic [P4_W-1:0] p4_pin_in,
	input wire logic [CAP_W-1:0] capture_trigger_inputs_out,
	input wire logic clk_out_en_in,
	input wire logic clk_out_sel_tpo_in,
	input wire logic programmable_clock_in,
	input wire logic timer_prescaler_in,
	input wire logic [P6_W-1:0] p6_pin_out,
	input wire logic [P6_W-1:0] p6_pin_oe_out,
	input wire logic [P9_W-1:0] p9_pin_out,
	input wire logic [P9_W-1:0] p9_pin_oe_out,
	input wire logic [SEG_PAIRS-1:0] lcd_display_control_reg_in,
	input wire logic [SEG_W-1:0] segment_drive_in,
	input wire logic [COM_W-1:0] common_drive_in,
	input wire logic [SEG_FIX_W-1:0] segment_outputs_out,
	input wire logic [COM_W-1:0] common_outputs_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	// Pin samples pass unreset sync stages, so wait five edges
	logic [2:0] since_r;
	always_ff @(posedge clk_in) begin
		if (srst_in) since_r <= 3'h0;
		else if (since_r != 3'h7) since_r <= since_r + 3'h1;
	end
	wire logic live = (since_r != 3'h0);
	wire logic warm = (since_r >= 3'h5);
	wire logic [15:0] m = {{4{meter_grp_en_in[3]}}, {4{meter_grp_en_in[2]}},
		{4{meter_grp_en_in[1]}}, {4{meter_grp_en_in[0]}}};
	logic [7:0] sel9;
	logic [7:0] seg9;
	for (genvar i = 0; i < 8; i++) begin : g9
		assign sel9[i] = lcd_display_control_reg_in[3 - i / 2];
		assign seg9[i] = segment_drive_in[12 - i];
	end
	property p_rst_idle;
		@(posedge clk_in) disable iff (1'h0) srst_in |=> p23_pin_oe_out == 16'h0
			&& p0_pin_oe_out == 8'h0 && ext_irq_inputs_out == 3'h0;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
	property p_dir;
		live && !$past(sio_a_en_in) |-> p0_pin_oe_out == $past(p0_dir_in);
	endproperty
	a_dir: assert property (p_dir) else $error("port0 drive mismatch");
	property p_pull;
		live && !$past(sio_a_en_in) |-> p0_pullup_out == $past(p0_pullup_en_in & ~p0_dir_in);
	endproperty
	a_pull: assert property (p_pull) else $error("pull-up mismatch");
	property p_ana;
		live |-> (p1_read_out & $past(analog_sel_in)) == 5'h0;
	endproperty
	a_ana: assert property (p_ana) else $error("analog bit read");
	property p_meter;
		live |-> p23_pin_oe_out == $past(p23_dir_in | m) && (p23_pin_out & p23_pin_oe_out)
			== $past(((meter_drive_outputs_in & m) | (p23_latch_in & ~m)) & (p23_dir_in | m));
	endproperty
	a_meter: assert property (p_meter) else $error("port2/3 drive mismatch");
	property p_seg;
		live |-> (p9_pin_oe_out & $past(sel9)) == $past(sel9)
			&& (p9_pin_out & $past(sel9)) == $past(seg9 & sel9);
	endproperty
	a_seg: assert property (p_seg) else $error("segment pin mismatch");
	property p_irq(int k);
		warm |-> ext_irq_inputs_out[k] == (($past(p0_pin_in[k], 3) && !$past(p0_pin_in[k], 4)
			&& $past(irq_edge_in[k]) inside {EDGE_RISE, EDGE_BOTH})
			|| (!$past(p0_pin_in[k], 3) && $past(p0_pin_in[k], 4)
			&& $past(irq_edge_in[k]) inside {EDGE_FALL, EDGE_BOTH}));
	endproperty
	for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
		a_irq: assert property (p_irq(i)) else $error("interrupt pulse mismatch");
	end
	property p_fixed;
		live |-> segment_outputs_out == $past(segment_drive_in[4:0])
			&& common_outputs_out == $past(common_drive_in);
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed LCD output mismatch");
	property p_cap;
		warm |-> capture_trigger_inputs_out == $past(p4_pin_in[2:0], 3);
	endproperty
	a_cap: assert property (p_cap) else $error("capture input mismatch");
	property p_clk;
		live && $past(clk_out_en_in) |-> p6_pin_oe_out[0] && p6_pin_out[0]
			== $past(clk_out_sel_tpo_in ? timer_prescaler_in : programmable_clock_in);
	endproperty
	a_clk: assert property (p_clk) else $error("clock pin mismatch");
	c_irq: cover property (ext_irq_inputs_out != 3'h0);
	c_meter: cover property (live && p23_pin_oe_out == 16'hFFFF);
	c_seg: cover property (live && p9_pin_oe_out == 8'hFF);
endmodule : ppfm_port_mux_monitor

// ===== tb/ppfm_board_model.sv
`timescale 1ns/10ps
module ppfm_board_model #(
	parameter int W = 8
) (
	input wire logic [W-1:0] oe_in,
	input wire logic [W-1:0] drv_in,
	input wire logic [W-1:0] pullup_in,
	input wire logic [W-1:0] ext_en_in,
	input wire logic [W-1:0] ext_in,
	output logic [W-1:0] pin_out
);
	// Board drives weakly, so the device wins; idle pins follow the pull-up, high when it is on and low otherwise
	assign pin_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_in)
		| (~oe_in & ~ext_en_in & pullup_in);
endmodule : ppfm_board_model

// ===== tb/testbench.sv
`timescale 1ns/10ps
module testbench;
	import ppfm_pkg::*;
	logic clk_in, srst_in, sio_a_en_in, sio_a_sck_oe_in, sio_a_sck_in, sio_a_so_in, sio_b_en_in;
	logic sio_b_sck_oe_in, sio_b_sck_in, sio_b_so_in, uart_en_in, uart_txd_in, clk_out_en_in;
	logic clk_out_sel_tpo_in, programmable_clock_in, timer_prescaler_in, sound_gen_en_in;
	logic sound_gen_in, sio_a_sck_out, sio_a_si_out, sio_b_sck_out, sio_b_si_out, uart_rxd_out;
	logic [7:0] p0_pin_in, p0_latch_in, p0_dir_in, p0_pullup_en_in, p0_pin_out, p0_pin_oe_out;
	logic [7:0] p0_pullup_out, p0_read_out, p0_ext, p0_ext_en, p9_pin_in, p9_latch_in, p9_dir_in;
	logic [7:0] p9_pin_out, p9_pin_oe_out, p9_read_out, lcd_display_control_reg_in;
	logic [4:0] p1_pin_in, analog_sel_in, p1_read_out, p4_pin_in, p4_latch_in, p4_dir_in;
	logic [4:0] p4_pin_out, p4_pin_oe_out, p4_read_out, p5_pin_in, p5_latch_in, p5_dir_in;
	logic [4:0] p5_pin_out, p5_pin_oe_out, p5_read_out, segment_outputs_out;
	logic [15:0] p23_latch_in, p23_dir_in, meter_drive_outputs_in, p23_pin_out, p23_pin_oe_out;
	logic [3:0] meter_grp_en_in, common_drive_in, common_outputs_out;
	logic [2:0] ext_irq_inputs_out, capture_trigger_inputs_out;
	logic [1:0] timer8_io_oe_in, timer8_io_drive_in, timer8_io_pins_out;
	logic [1:0] p6_pin_in, p6_latch_in, p6_dir_in, p6_pin_out, p6_pin_oe_out, p6_read_out;
	logic [6:0] p8_pin_in, p8_latch_in, p8_dir_in, p8_pin_out, p8_pin_oe_out, p8_read_out;
	logic [19:0] segment_drive_in;
	ppfm_edge_type irq_edge_in [IRQ_W];
	logic [255:0] rv;
	logic [2:0] exp_q [$];
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;
	ppfm_port_mux ppfm_port_mux_i (.*);
	ppfm_board_model #(.W(8)) ppfm_board_model_i (.oe_in(p0_pin_oe_out), .drv_in(p0_pin_out),
		.pullup_in(p0_pullup_out), .ext_en_in(p0_ext_en), .ext_in(p0_ext), .pin_out(p0_pin_in));
	task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic final_report;
		$display("Counts: %0d compared, %0d wrong", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	task automatic apply;
		{p0_latch_in, p0_dir_in, p0_pullup_en_in, sio_a_en_in, sio_a_sck_oe_in, sio_a_sck_in,
			sio_a_so_in, p1_pin_in, analog_sel_in, p23_latch_in, p23_dir_in, meter_grp_en_in,
			meter_drive_outputs_in, p4_pin_in, p4_latch_in, p4_dir_in, timer8_io_oe_in,
			timer8_io_drive_in, p5_pin_in, p5_latch_in, p5_dir_in, sio_b_en_in, sio_b_sck_oe_in,
			sio_b_sck_in, sio_b_so_in, uart_en_in, uart_txd_in, p6_pin_in, p6_latch_in, p6_dir_in,
			clk_out_en_in, clk_out_sel_tpo_in, programmable_clock_in, timer_prescaler_in,
			sound_gen_en_in, sound_gen_in, p8_pin_in, p8_latch_in, p8_dir_in, p9_pin_in,
			p9_latch_in, p9_dir_in, lcd_display_control_reg_in, segment_drive_in, common_drive_in,
			p0_ext, p0_ext_en} = rv[234:0];
	endtask : apply
	initial begin
		clk_in = 1'h0;
		forever #12.5 clk_in = ~clk_in;
	end
	// Limit well above the roughly 970 cycles of the run
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 4000) begin
			miscompares++;
			final_report();
		end
	end
	// Interrupt pulses are matched against notes in arrival order
	always @(negedge clk_in) begin
		if (!srst_in && ext_irq_inputs_out !== 3'h0) begin
			if (exp_q.size() == 0) chk("stray irq", 40'h0, 40'(ext_irq_inputs_out));
			else chk("irq", 40'(exp_q.pop_front()), 40'(ext_irq_inputs_out));
		end
	end
	initial begin
		void'($urandom(26));
		srst_in = 1'h1;
		rv = '0;
		apply();
		for (int i = 0; i < IRQ_W; i++) irq_edge_in[i] = ppfm_edge_type'(2'h3);
		repeat (3) @(posedge clk_in);
		#2;
		chk("p23 oe", 40'h0, 40'(p23_pin_oe_out));
		chk("bidir oe", 40'h0, {p0_pin_oe_out, p4_pin_oe_out, p5_pin_oe_out, p6_pin_oe_out,
			p8_pin_oe_out, p9_pin_oe_out});
		srst_in = 1'h0;
		$display("reset test done");
		lcd_display_control_reg_in = 8'h81;
		segment_drive_in = 20'h80075;
		common_drive_in = 4'hA;
		meter_grp_en_in = 4'h2;
		meter_drive_outputs_in = 16'h00A0;
		repeat (2) @(posedge clk_in);
		#2;
		chk("p9 seg", 40'hC0C0, {p9_pin_oe_out, p9_pin_out});
		chk("p8 seg", 40'h0101, {1'h0, p8_pin_oe_out, 1'h0, p8_pin_out});
		chk("fixed", 40'h15A, {3'h0, segment_outputs_out, common_outputs_out});
		chk("meter", 40'h00F000A0, {p23_pin_oe_out, p23_pin_out});
		$display("lcd and meter test done");
		repeat (200) begin
			for (int k = 0; k < 8; k++) rv[k*32+:32] = $urandom();
			@(posedge clk_in);
			#2;
			apply();
			repeat (3) @(posedge clk_in);
			#2;
			chk("p1 read", 40'(p1_pin_in & ~analog_sel_in), 40'(p1_read_out));
			chk("capture", 40'(p4_pin_in[2:0]), 40'(capture_trigger_inputs_out));
			chk("timer io", 40'(p4_pin_in[4:3]), 40'(timer8_io_pins_out));
			chk("p5 oe", 40'({uart_en_in | p5_dir_in[4], ~uart_en_in & p5_dir_in[3],
				~sio_b_en_in & p5_dir_in[2], sio_b_en_in | p5_dir_in[1],
				sio_b_en_in ? sio_b_sck_oe_in : p5_dir_in[0]}), 40'(p5_pin_oe_out));
			chk("p5 samples", 40'({p5_pin_in[3], p5_pin_in[2]}),
				40'({uart_rxd_out, sio_b_si_out}));
			chk("sound", 40'(sound_gen_en_in ? {1'h1, sound_gen_in} : {p6_dir_in[1], p6_latch_in[1]}),
				40'({p6_pin_oe_out[1], p6_pin_out[1]}));
		end
		$display("random test done");
		rv = '0;
		apply();
		p0_ext_en = 8'hFF;
		repeat (6) @(posedge clk_in);
		for (int i = 0; i < IRQ_W; i++) begin
			for (int c = 0; c < 4; c++) begin
				#2;
				irq_edge_in[i] = ppfm_edge_type'(c[1:0]);
				repeat (2) @(posedge clk_in);
				#2;
				if (c == 0 || c == 2) exp_q.push_back(3'h1 << i);
				p0_ext[i] = 1'h1;
				repeat (5) @(posedge clk_in);
				#2;
				if (c == 1 || c == 2) exp_q.push_back(3'h1 << i);
				p0_ext[i] = 1'h0;
				repeat (5) @(posedge clk_in);
				#2;
				irq_edge_in[i] = ppfm_edge_type'(2'h3);
				@(posedge clk_in);
			end
		end
		repeat (4) @(posedge clk_in);
		chk("irq left", 40'h0, 40'(exp_q.size()));
		$display("interrupt test done");
		final_report();
	end
endmodule : testbench
bind ppfm_port_mux ppfm_port_mux_monitor ppfm_port_mux_monitor_i (.*);
